/* File: hw/shost_defines.vh */
// constants for the two-wire sensor host controller
`ifndef SHOST_DEFINES_VH
`define SHOST_DEFINES_VH
`define SHOST_TARGET_ADDR 7'h5F
`define SHOST_DIR_WRITE 1'b0
`define SHOST_DIR_READ 1'b1
`define SHOST_AUTOINC_BIT 7
`define SHOST_CLK_HZ 10000000
`define SHOST_SCL_HZ 400000
`define SHOST_QTR_CYC ((`SHOST_CLK_HZ / `SHOST_SCL_HZ) / 4)
`define SHOST_FIFO_DEPTH 8
`define SHOST_FIFO_AW 3
`endif

/* File: hw/shost_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module shost_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_reg;
	reg [AW-1:0] rptr_reg;
	reg [AW:0] count_reg;
	reg ready_reg;
	wire do_wr;
	wire do_rd;
	assign in_ready = ready_reg;
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem[rptr_reg];
	assign do_wr = ce & in_valid & in_ready;
	assign do_rd = ce & out_valid & out_ready;
	always @(posedge mclk) begin
		if (do_wr) begin
			mem[wptr_reg] <= in_data;
		end
	end
	always @(posedge mclk) begin
		if (rst) begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			ready_reg <= 1'b1;
		end else begin
			if (do_wr) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (do_rd) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count_reg <= count_reg + 1'b1;
				// full once this write takes the last free word
				ready_reg <= (count_reg != DEPTH[AW:0] - {{AW{1'b0}}, 1'b1});
			end else if (do_rd && !do_wr) begin
				count_reg <= count_reg - 1'b1;
				ready_reg <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hw/shost_master.v */
// two-wire bus master that reads and writes the sensor register set
// Summary of operation
// RULE_01: hold mode-select high to use two-wire.
// RULE_02: start is data fall with clock high.
// RULE_03: stop is data rise with clock high.
// RULE_04: first byte is address plus direction.
// RULE_05: target address 1011111, BEh/BFh.
// RULE_06: receiver pulls data low in ack.
// RULE_07: device acknowledges address and received bytes.
// RULE_08: pointer byte: seven bits plus auto-increment.
// RULE_09: pointer top bit set means auto-increment.
// RULE_10: write: start, address, pointer, data, stop.
// RULE_11: read: pointer write, repeated start, read.
// RULE_12: bytes eight bits, msb first, unlimited; code bounds a transfer by the 8-bit cmd_len, 0 taken as 1.
// RULE_13: master acks more, no-ack on last.
// RULE_14: wait while clock line held low.
// RULE_15: no ack on address aborts transfer.
// RULE_16: every transaction ends with stop.
// RULE_17: bus clock at most fast-mode rate; code uses 6-cycle quarters at 10 MHz, about 417 kHz.
// RULE_18: never send high-speed master code.
// RULE_19: top bit clear keeps pointer fixed.
`timescale 1ns/100ps
`default_nettype none
`include "shost_defines.vh"
module shost_master #(
	parameter QTR = `SHOST_QTR_CYC,
	parameter DEPTH = `SHOST_FIFO_DEPTH,
	parameter AW = `SHOST_FIFO_AW
) (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire cmd_valid,
	output reg cmd_ready,
	input wire cmd_read,
	input wire [6:0] cmd_reg_addr,
	input wire cmd_autoinc,
	input wire [7:0] cmd_len,
	input wire [7:0] wr_data,
	input wire wr_valid,
	output wire wr_ready,
	output reg [7:0] rd_data,
	output reg rd_valid,
	output reg done,
	output reg nack_err,
	output reg mode_sel_o,
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe
);
	localparam S_IDLE = 4'd0;
	localparam S_START = 4'd1;
	localparam S_BIT = 4'd2;
	localparam S_ACK = 4'd3;
	localparam S_NEXT = 4'd4;
	localparam S_RSTART = 4'd5;
	localparam S_STOP = 4'd6;
	localparam S_DONE = 4'd7;
	localparam PH_ADDR = 2'd0;
	localparam PH_PTR = 2'd1;
	localparam PH_WR = 2'd2;
	localparam PH_RD = 2'd3;
	reg [3:0] state_reg;
	reg [1:0] phase_reg;
	reg [1:0] qtr_reg;
	reg [15:0] tick_reg;
	reg [2:0] bit_reg;
	reg [7:0] sh_reg;
	reg [7:0] left_reg;
	reg read_reg;
	reg second_reg;
	reg last_ack_reg;
	wire [7:0] f_data;
	wire f_valid;
	reg f_take;
	wire tick;
	wire stretch;
	shost_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.in_data(wr_data),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_take)
	);
	// hold quarter timer while a released clock is still low
	assign stretch = scl_oe == 1'b0 && scl_i == 1'b0 && qtr_reg == 2'd2; // RULE_14
	assign tick = (tick_reg == QTR[15:0] - 16'h0001) && !stretch; // RULE_17
	always @* begin
		f_take = 1'b0;
		if (ce && tick && state_reg == S_NEXT && phase_reg == PH_WR &&
			last_ack_reg && left_reg > 8'h01) begin
			f_take = f_valid;
		end
	end
	always @(posedge mclk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			phase_reg <= PH_ADDR;
			qtr_reg <= 2'd0;
			tick_reg <= 16'h0000;
			bit_reg <= 3'd7;
			sh_reg <= 8'h00;
			left_reg <= 8'h00;
			read_reg <= 1'b0;
			second_reg <= 1'b0;
			last_ack_reg <= 1'b0;
			cmd_ready <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
			nack_err <= 1'b0;
			mode_sel_o <= 1'b1;
			scl_o <= 1'b0;
			scl_oe <= 1'b0;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			mode_sel_o <= 1'b1; // RULE_01
			rd_valid <= 1'b0;
			done <= 1'b0;
			cmd_ready <= 1'b0;
			if (state_reg == S_IDLE) begin
				tick_reg <= 16'h0000;
				qtr_reg <= 2'd0;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				if (cmd_valid && !cmd_ready) begin
					cmd_ready <= 1'b1;
					nack_err <= 1'b0;
					read_reg <= cmd_read;
					second_reg <= 1'b0;
					left_reg <= (cmd_len == 8'h00) ? 8'h01 : cmd_len; // RULE_12
					// address byte 0xBE, never a 00001xxx code
					sh_reg <= {`SHOST_TARGET_ADDR, `SHOST_DIR_WRITE}; // RULE_05 RULE_18
					phase_reg <= PH_ADDR;
					bit_reg <= 3'd7;
					state_reg <= S_START;
				end
			end else if (stretch) begin
				// restart the quarter once the clock line is let go
				tick_reg <= 16'h0000; // RULE_14
			end else if (!tick) begin
				tick_reg <= tick_reg + 16'h0001;
			end else begin
				tick_reg <= 16'h0000;
				qtr_reg <= qtr_reg + 2'd1;
				case (state_reg)
				S_START, S_RSTART: begin
					// q0 release data, q1 release clock, q2 data low
					if (qtr_reg == 2'd0) begin
						sda_oe <= 1'b0;
					end else if (qtr_reg == 2'd1) begin
						scl_oe <= 1'b0;
					end else if (qtr_reg == 2'd2) begin
						sda_oe <= 1'b1; // RULE_02 RULE_11
					end else begin
						scl_oe <= 1'b1;
						state_reg <= S_BIT;
					end
				end
				S_BIT: begin
					if (qtr_reg == 2'd0) begin
						if (phase_reg == PH_RD) begin
							sda_oe <= 1'b0;
						end else begin
							sda_oe <= ~sh_reg[bit_reg]; // RULE_12
						end
					end else if (qtr_reg == 2'd1) begin
						scl_oe <= 1'b0;
					end else if (qtr_reg == 2'd2) begin
						if (phase_reg == PH_RD) begin
							sh_reg[bit_reg] <= sda_i;
						end
					end else begin
						scl_oe <= 1'b1;
						bit_reg <= bit_reg - 3'd1;
						if (bit_reg == 3'd0) begin
							state_reg <= S_ACK;
						end
					end
				end
				S_ACK: begin
					if (qtr_reg == 2'd0) begin
						if (phase_reg == PH_RD) begin
							// ack all but the final byte
							sda_oe <= (left_reg != 8'h01); // RULE_06 RULE_13
						end else begin
							sda_oe <= 1'b0; // RULE_06
						end
					end else if (qtr_reg == 2'd1) begin
						scl_oe <= 1'b0;
					end else if (qtr_reg == 2'd2) begin
						last_ack_reg <= ~sda_i; // RULE_07
						if (phase_reg == PH_RD) begin
							rd_data <= sh_reg;
							rd_valid <= 1'b1;
						end
					end else begin
						scl_oe <= 1'b1;
						state_reg <= S_NEXT;
					end
				end
				S_NEXT: begin
					qtr_reg <= 2'd0;
					bit_reg <= 3'd7;
					if (phase_reg != PH_RD && !last_ack_reg) begin
						nack_err <= 1'b1; // RULE_15
						state_reg <= S_STOP;
					end else if (phase_reg == PH_ADDR) begin
						phase_reg <= second_reg ? PH_RD : PH_PTR;
						sh_reg <= {cmd_autoinc, cmd_reg_addr}; // RULE_08 RULE_09 RULE_19
						state_reg <= S_BIT;
					end else if (phase_reg == PH_PTR) begin
						if (read_reg) begin
							second_reg <= 1'b1;
							phase_reg <= PH_ADDR;
							sh_reg <= {`SHOST_TARGET_ADDR, `SHOST_DIR_READ}; // RULE_04
							state_reg <= S_RSTART; // RULE_11
						end else begin
							phase_reg <= PH_WR;
							state_reg <= S_NEXT;
							qtr_reg <= 2'd0;
							last_ack_reg <= 1'b1;
							left_reg <= left_reg + 8'h01;
						end
					end else begin
						left_reg <= left_reg - 8'h01;
						if (left_reg == 8'h01) begin
							state_reg <= S_STOP; // RULE_16
						end else if (phase_reg == PH_RD) begin
							state_reg <= S_BIT;
						end else if (f_valid) begin
							sh_reg <= f_data; // RULE_10
							state_reg <= S_BIT;
						end else begin
							left_reg <= left_reg;
							qtr_reg <= 2'd0;
						end
					end
				end
				S_STOP: begin
					if (qtr_reg == 2'd0) begin
						sda_oe <= 1'b1;
					end else if (qtr_reg == 2'd1) begin
						scl_oe <= 1'b0;
					end else if (qtr_reg == 2'd2) begin
						sda_oe <= 1'b0; // RULE_03
					end else begin
						state_reg <= S_DONE;
					end
				end
				S_DONE: begin
					done <= 1'b1;
					state_reg <= S_IDLE;
				end
				default: begin
					state_reg <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/shost_master_props.sv */
// port checks for the two-wire host controller
`timescale 1ns/100ps
`default_nettype none
module shost_master_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_ready,
	input wire logic done,
	input wire logic nack_err,
	input wire logic mode_sel_o,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_o,
	input wire logic sda_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_mode_sel_high: assert property (mode_sel_o)
		else $error("mode low");
	chk_open_drain: assert property (!scl_o && !sda_o)
		else $error("line driven high");
	chk_start_soon: assert property (cmd_ready |-> ##[1:40] sda_oe)
		else $error("no start");
	chk_stop_at_done: assert property (done |-> !sda_oe && !scl_oe)
		else $error("bus held at done");
	chk_stretch_wait: assert property (!scl_oe && !scl_i |=> !scl_oe)
		else $error("clock pulled in wait");
	chk_clock_high: assert property ($fell(scl_oe) |-> !scl_oe [*4])
		else $error("clock high short");
	chk_nack_done: assert property ($rose(nack_err) |-> ##[0:100] done)
		else $error("no end after nack");
	chk_nack_clear: assert property (cmd_ready |-> !nack_err)
		else $error("nack kept");
endmodule
bind shost_master shost_master_chk shost_master_chk_i (.*);
`default_nettype wire

/* File: verif/shost_dev_model.sv */
// device model: two-wire sensor with 128 byte registers
`timescale 1ns/100ps
`default_nettype none
module shost_dev_model (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic stretch,
	input wire logic deaf,
	output logic sda_pull,
	output logic scl_pull
);
	logic [7:0] mem[128], sh;
	logic [6:0] ptr;
	logic inc, mack;
	int bc, st = 4;
	initial begin
		sda_pull = 1'h0;
		scl_pull = 1'h0;
	end
	always @(negedge sda_i) if (scl_i) begin
		bc = -1;
		st = 0;
	end
	always @(posedge sda_i) if (scl_i) st = 4;
	always @(posedge scl_i) begin
		if (bc < 8 && st < 3) sh = {sh[6:0], sda_i};
		mack = !sda_i;
	end
	always @(negedge scl_i) if (st < 4) begin
		bc++;
		if (bc == 8 && st < 3) begin
			sda_pull = !deaf && (st > 0 || sh[7:1] == 7'h5F);
			if (st == 2) mem[ptr] = sh;
			if (st == 2) ptr = ptr + {6'h00, inc};
			if (st == 1) {inc, ptr} = sh;
			st = !sda_pull ? 4 : st > 0 ? 2 : sh[0] ? 3 : 1;
		end else if (bc == 9) begin
			bc = 0;
			sda_pull = 1'h0;
			if (!mack) st = 4;
			sh = mem[ptr];
			if (st == 3) ptr = ptr + {6'h00, inc};
			if (st == 3) sda_pull = !sh[7];
		end else if (st == 3) sda_pull = bc < 8 && !sh[7 - bc];
	end
	always @(negedge scl_i) if (stretch) begin
		scl_pull = 1'h1;
		#1500 scl_pull = 1'h0;
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// bench: host controller against a device model
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct {logic i; logic [6:0] a; logic [7:0] n, b;} shost_row_t;
	shost_row_t rows[3] = '{'{1'h1, 7'h10, 8'h04, 8'h51},
		'{1'h0, 7'h20, 8'h03, 8'hC2}, '{1'h1, 7'h7E, 8'h01, 8'h0F}};
	logic mclk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, cmd_read = 1'h0;
	logic cmd_autoinc = 1'h0, wr_valid = 1'h0, stretch = 1'h0, deaf = 1'h0;
	logic sda_pull, scl_pull;
	logic [6:0] cmd_reg_addr = 7'h00;
	logic [7:0] cmd_len = 8'h01, wr_data = 8'h00, shadow[128], q[$];
	wire cmd_ready, wr_ready, rd_valid, done, nack_err, mode_sel_o;
	wire scl_o, scl_oe, sda_o, sda_oe;
	wire [7:0] rd_data;
	wire scl_i = !(scl_oe || scl_pull);
	wire sda_i = !(sda_oe || sda_pull);
	int bad_count = 0, checks = 0;
	shost_master #(.QTR(2)) shost_master_i (.ce(1'h1), .*);
	shost_dev_model shost_dev_model_i (.*);
	initial forever #50 mclk = ~mclk;
	always @(negedge mclk) if (rd_valid === 1'h1) q.push_back(rd_data);
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task push(input logic [7:0] b);
		wr_data <= b;
		wr_valid <= 1'h1;
		@(negedge mclk);
		while (wr_ready !== 1'h1) @(negedge mclk);
		@(posedge mclk);
	endtask
	task run(input logic r, input logic [6:0] a, input logic i,
		input logic [7:0] n);
		{cmd_read, cmd_reg_addr, cmd_autoinc, cmd_len} <= {r, a, i, n};
		cmd_valid <= 1'h1;
		@(negedge mclk);
		while (cmd_ready !== 1'h1) @(negedge mclk);
		@(posedge mclk);
		cmd_valid <= 1'h0;
		repeat (9000) if (done !== 1'h1) @(negedge mclk);
		chk({7'h00, done}, 8'h01);
		@(posedge mclk);
	endtask
	task idle_chk;
		@(negedge mclk);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		chk({7'h00, mode_sel_o}, 8'h01);
		@(posedge mclk);
	endtask
	task row(input shost_row_t r);
		logic [6:0] p;
		p = r.a;
		for (int j = 0; j < r.n; j++) begin
			push(r.b + j[7:0]);
			shadow[p] = r.b + j[7:0];
			p = p + {6'h00, r.i};
		end
		wr_valid <= 1'h0;
		@(negedge mclk);
		chk({7'h00, wr_ready}, {7'h00, r.n != 8'h08});
		@(posedge mclk);
		q = {};
		run(1'h0, r.a, r.i, r.n);
		chk({7'h00, nack_err}, 8'h00);
		run(1'h1, r.a, r.i, r.n);
		chk(8'(q.size()), r.n);
		p = r.a;
		for (int j = 0; j < r.n; j++) begin
			chk(q[j], shadow[p]);
			p = p + {6'h00, r.i};
		end
		$display("test row done %0t", $time);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		idle_chk();
		$display("test idle done");
		foreach (rows[k]) row(rows[k]);
		stretch = 1'h1;
		row('{1'h1, 7'h40, 8'h08, 8'h80});
		stretch = 1'h0;
		deaf = 1'h1;
		run(1'h1, 7'h10, 1'h1, 8'h01);
		chk({7'h00, nack_err}, 8'h01);
		deaf = 1'h0;
		q = {};
		run(1'h1, 7'h10, 1'h1, 8'h01);
		chk(q[0], shadow[16]);
		$display("test nack done");
		cmd_valid <= 1'h1;
		repeat (2) @(posedge mclk);
		cmd_valid <= 1'h0;
		repeat (150) @(posedge mclk);
		rst <= 1'h1;
		repeat (2) @(posedge mclk);
		rst <= 1'h0;
		idle_chk();
		$display("test reset done");
		close_out();
	end
	initial begin
		#(100 * 40000);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
